// >>> common/cor_pkg.sv
`default_nettype none
package cor_pkg;
  // ----------------------------------------------------------------
  // Register numbers carried in the low nibble of each serial word
  // ----------------------------------------------------------------
  localparam logic [3:0] COR_ADDR_OUT_LAST = 4'h7;
  localparam logic [3:0] COR_ADDR_LOCK = 4'hb;
  localparam logic [3:0] COR_ADDR_PLL = 4'he;
  localparam logic [3:0] COR_ADDR_FB = 4'hf;
  localparam int COR_NUM_OUT = 8;
  localparam int COR_WORD_W = 32;
  localparam int COR_ADDR_W = 4;
  // ----------------------------------------------------------------
  // Per-output register fields
  // ----------------------------------------------------------------
  localparam int COR_RESET_BIT = 31;
  localparam int COR_MUX_HI = 18;
  localparam int COR_MUX_LO = 17;
  localparam int COR_EN_BIT = 16;
  localparam int COR_DIV_HI = 15;
  localparam int COR_DIV_LO = 8;
  localparam int COR_DLY_HI = 7;
  localparam int COR_DLY_LO = 4;
  localparam logic [31:0] COR_OUT_DEFAULT = 32'h0000_0100;
  // ----------------------------------------------------------------
  // Lock-detect and PLL register fields
  // ----------------------------------------------------------------
  localparam int COR_PRESCALE_BIT = 15;
  localparam logic [31:0] COR_LOCK_DEFAULT = 32'h0000_0000;
  localparam int COR_FIXED_HI = 31;
  localparam int COR_FIXED_LO = 28;
  localparam logic [3:0] COR_FIXED_VAL = 4'h2;
  localparam int COR_GLOBAL_EN_BIT = 27;
  localparam int COR_SLEEP_BIT = 26;
  localparam int COR_FLOAT_BIT = 25;
  localparam int COR_POL_BIT = 24;
  localparam int COR_LDSEL_HI = 23;
  localparam int COR_LDSEL_LO = 20;
  localparam int COR_RDIV_HI = 19;
  localparam int COR_RDIV_LO = 8;
  localparam logic [31:0] COR_PLL_DEFAULT = 32'h2800_0a00;
  localparam int COR_GAIN_HI = 31;
  localparam int COR_GAIN_LO = 30;
  localparam int COR_NDIV_HI = 25;
  localparam int COR_NDIV_LO = 8;
  localparam logic [31:0] COR_FB_DEFAULT = 32'h0002_f800;
  // ----------------------------------------------------------------
  // Path select encodings and added latency in picoseconds
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    COR_PATH_BYPASS = 2'h0,
    COR_PATH_DIV = 2'h1,
    COR_PATH_DLY = 2'h2,
    COR_PATH_DIV_DLY = 2'h3
  } cor_path_t;
  localparam logic [11:0] COR_LAT_DIV_PS = 12'd100;
  localparam logic [11:0] COR_LAT_DLY_PS = 12'd400;
  localparam logic [11:0] COR_LAT_DIV_DLY_PS = 12'd500;
  localparam logic [11:0] COR_DLY_STEP_PS = 12'd150;
  localparam logic [8:0] COR_RATIO_THROUGH = 9'd1;
endpackage
`default_nettype wire

// >>> rtl/cor_regs.sv
`timescale 1ns/1ns
`default_nettype none
module cor_regs (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ser_clk_i,
  input wire logic ser_data_i,
  input wire logic ser_latch_i,
  input wire logic outputs_gate_pin_i,
  output logic [7:0][1:0] output_path_select_o,
  output logic [7:0][8:0] divide_ratio_o,
  output logic [7:0][3:0] output_delay_code_o,
  output logic [7:0][11:0] added_latency_ps_o,
  output logic [7:0] clock_output_en_o,
  output logic [7:0] divide_code_invalid_o,
  output logic lock_detect_prescale_o,
  output logic all_outputs_enable_o,
  output logic device_sleep_o,
  output logic pump_float_o,
  output logic pump_polarity_o,
  output logic [1:0] pump_gain_o,
  output logic [3:0] lock_indicator_sel_o,
  output logic [11:0] ref_divider_o,
  output logic ref_divider_invalid_o,
  output logic [17:0] feedback_divider_o,
  output logic feedback_divider_invalid_o,
  output logic pll_fixed_bits_bad_o
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Latency added over bypass: fixed part, plus programmed steps on the two delay paths
  function automatic logic [11:0] path_latency(input logic [1:0] mux,
                                               input logic [3:0] dly);
    logic [11:0] steps;
    steps = 12'(dly) * cor_pkg::COR_DLY_STEP_PS;
    case (mux)
      cor_pkg::COR_PATH_DIV: path_latency = cor_pkg::COR_LAT_DIV_PS;
      cor_pkg::COR_PATH_DLY:
        path_latency = cor_pkg::COR_LAT_DLY_PS + steps;
      cor_pkg::COR_PATH_DIV_DLY:
        path_latency = cor_pkg::COR_LAT_DIV_DLY_PS + steps;
      default: path_latency = 12'h000;
    endcase
  endfunction

  // Effective ratio seen by the output; one when divider is out
  function automatic logic [8:0] eff_ratio(input logic [1:0] mux,
                                           input logic [7:0] code);
    if (mux == cor_pkg::COR_PATH_DIV || mux == cor_pkg::COR_PATH_DIV_DLY) begin
      eff_ratio = {code, 1'b0};
    end else begin
      eff_ratio = cor_pkg::COR_RATIO_THROUGH;
    end
  endfunction

  // ----------------------------------------------------------------
  // Serial pin synchronisers
  // ----------------------------------------------------------------
  // The serial clock is only a sampled input; 10 MHz against an
  // 800 ns link period gives four samples per phase.
  logic [3:0] meta_ff;
  logic [3:0] sync_ff;
  logic ser_clk_d_ff;
  logic ser_latch_d_ff;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      // Latch idles high; starting it low would fake a commit of an
      // empty word into register 0 as reset is released
      meta_ff <= 4'h4;
      sync_ff <= 4'h4;
      ser_clk_d_ff <= 1'b0;
      ser_latch_d_ff <= 1'b1;
    end else begin
      meta_ff <= {outputs_gate_pin_i, ser_latch_i, ser_data_i, ser_clk_i};
      sync_ff <= meta_ff;
      ser_clk_d_ff <= sync_ff[0];
      ser_latch_d_ff <= sync_ff[2];
    end
  end

  logic clk_rise;
  logic latch_rise;
  logic gate_sync;
  assign clk_rise = sync_ff[0] & ~ser_clk_d_ff;
  assign latch_rise = sync_ff[2] & ~ser_latch_d_ff;
  assign gate_sync = sync_ff[3];

  // ----------------------------------------------------------------
  // Shift register
  // ----------------------------------------------------------------
  // Bits enter MSB first while latch is low; last 32 bits win
  logic [31:0] shift_ff;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      shift_ff <= 32'h0000_0000;
    end else if (clk_rise && !sync_ff[2]) begin
      shift_ff <= {shift_ff[30:0], sync_ff[1]};
    end
  end

  // ----------------------------------------------------------------
  // Register write decode
  // ----------------------------------------------------------------
  logic [3:0] wr_addr;
  logic soft_reset;
  assign wr_addr = shift_ff[cor_pkg::COR_ADDR_W-1:0];
  assign soft_reset = latch_rise && wr_addr == 4'h0 &&
                      shift_ff[cor_pkg::COR_RESET_BIT];

  logic [31:0] out_ctl_ff [cor_pkg::COR_NUM_OUT];
  logic [31:0] lock_ctl_ff;
  logic [31:0] pll_ctl_ff;
  logic [31:0] fb_ctl_ff;

  // Per-output registers; a register 0 word with the reset bit set is never stored
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || soft_reset) begin
      for (int i = 0; i < cor_pkg::COR_NUM_OUT; i++) begin
        out_ctl_ff[i] <= cor_pkg::COR_OUT_DEFAULT;
      end
    end else if (latch_rise && wr_addr <= cor_pkg::COR_ADDR_OUT_LAST) begin
      out_ctl_ff[wr_addr[2:0]] <= shift_ff;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || soft_reset) begin
      lock_ctl_ff <= cor_pkg::COR_LOCK_DEFAULT;
    end else if (latch_rise && wr_addr == cor_pkg::COR_ADDR_LOCK) begin
      lock_ctl_ff <= shift_ff;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || soft_reset) begin
      pll_ctl_ff <= cor_pkg::COR_PLL_DEFAULT;
    end else if (latch_rise && wr_addr == cor_pkg::COR_ADDR_PLL) begin
      pll_ctl_ff <= shift_ff;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || soft_reset) begin
      fb_ctl_ff <= cor_pkg::COR_FB_DEFAULT;
    end else if (latch_rise && wr_addr == cor_pkg::COR_ADDR_FB) begin
      fb_ctl_ff <= shift_ff;
    end
  end

  // ----------------------------------------------------------------
  // Global controls
  // ----------------------------------------------------------------
  logic sleep;
  logic global_en;
  assign sleep = pll_ctl_ff[cor_pkg::COR_SLEEP_BIT];
  assign global_en = pll_ctl_ff[cor_pkg::COR_GLOBAL_EN_BIT];

  // Lock-detect prescale, the only live bit of its register
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      lock_detect_prescale_o <= 1'b0;
    end else begin
      lock_detect_prescale_o <=
        lock_ctl_ff[cor_pkg::COR_PRESCALE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Reference side and mode bits
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      all_outputs_enable_o <= 1'b1;
      device_sleep_o <= 1'b0;
      pump_float_o <= 1'b0;
      pump_polarity_o <= 1'b0;
      lock_indicator_sel_o <= 4'h0;
      ref_divider_o <= 12'h00a;
      ref_divider_invalid_o <= 1'b0;
      pll_fixed_bits_bad_o <= 1'b0;
    end else begin
      all_outputs_enable_o <= global_en;
      device_sleep_o <= sleep;
      // Sleeping also floats the pump
      pump_float_o <= pll_ctl_ff[cor_pkg::COR_FLOAT_BIT] | sleep;
      // Zero negative, one positive
      pump_polarity_o <= pll_ctl_ff[cor_pkg::COR_POL_BIT];
      // Sleep parks the lock pin on its disabled code
      lock_indicator_sel_o <= sleep ? 4'h0 :
        pll_ctl_ff[cor_pkg::COR_LDSEL_HI:cor_pkg::COR_LDSEL_LO];
      ref_divider_o <=
        pll_ctl_ff[cor_pkg::COR_RDIV_HI:cor_pkg::COR_RDIV_LO];
      ref_divider_invalid_o <=
        pll_ctl_ff[cor_pkg::COR_RDIV_HI:cor_pkg::COR_RDIV_LO] == 12'h000;
      // Flags a host that broke the fixed pattern; the word is kept
      pll_fixed_bits_bad_o <=
        pll_ctl_ff[cor_pkg::COR_FIXED_HI:cor_pkg::COR_FIXED_LO] !=
        cor_pkg::COR_FIXED_VAL;
    end
  end

  // ----------------------------------------------------------------
  // Feedback side
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pump_gain_o <= 2'h0;
      feedback_divider_o <= 18'h002f8;
      feedback_divider_invalid_o <= 1'b0;
    end else begin
      pump_gain_o <= fb_ctl_ff[cor_pkg::COR_GAIN_HI:cor_pkg::COR_GAIN_LO];
      feedback_divider_o <=
        fb_ctl_ff[cor_pkg::COR_NDIV_HI:cor_pkg::COR_NDIV_LO];
      feedback_divider_invalid_o <=
        fb_ctl_ff[cor_pkg::COR_NDIV_HI:cor_pkg::COR_NDIV_LO] == 18'h00000;
    end
  end

  // ----------------------------------------------------------------
  // Per-output field slices
  // ----------------------------------------------------------------
  // Sync pin alignment (after divider writes) is the host's job and
  // has no state here; only static configuration is presented.
  logic [7:0][1:0] mux_field;
  logic [7:0][7:0] div_field;
  logic [7:0][3:0] dly_field;
  logic [7:0] en_field;

  always_comb begin
    for (int i = 0; i < cor_pkg::COR_NUM_OUT; i++) begin
      mux_field[i] =
        out_ctl_ff[i][cor_pkg::COR_MUX_HI:cor_pkg::COR_MUX_LO];
      div_field[i] =
        out_ctl_ff[i][cor_pkg::COR_DIV_HI:cor_pkg::COR_DIV_LO];
      dly_field[i] =
        out_ctl_ff[i][cor_pkg::COR_DLY_HI:cor_pkg::COR_DLY_LO];
      en_field[i] = out_ctl_ff[i][cor_pkg::COR_EN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Path select and delay code, straight copies of the fields
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      output_path_select_o <= 16'h0000;
    end else begin
      output_path_select_o <= mux_field;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      output_delay_code_o <= 32'h0000_0000;
    end else begin
      output_delay_code_o <= dly_field;
    end
  end

  // ----------------------------------------------------------------
  // Effective ratio and added latency
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < cor_pkg::COR_NUM_OUT; i++) begin
        divide_ratio_o[i] <= cor_pkg::COR_RATIO_THROUGH;
      end
    end else begin
      for (int i = 0; i < cor_pkg::COR_NUM_OUT; i++) begin
        divide_ratio_o[i] <= eff_ratio(mux_field[i], div_field[i]);
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < cor_pkg::COR_NUM_OUT; i++) begin
        added_latency_ps_o[i] <= 12'h000;
      end
    end else begin
      for (int i = 0; i < cor_pkg::COR_NUM_OUT; i++) begin
        added_latency_ps_o[i] <=
          path_latency(mux_field[i], dly_field[i]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Output enables and divide code check
  // ----------------------------------------------------------------
  // Enable bit counts only under global enable, open gate, awake;
  // the gate lags its pin by the synchroniser depth.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      clock_output_en_o <= 8'h00;
    end else begin
      for (int i = 0; i < cor_pkg::COR_NUM_OUT; i++) begin
        clock_output_en_o[i] <= en_field[i] && global_en && gate_sync &&
          !sleep;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      divide_code_invalid_o <= 8'h00;
    end else begin
      for (int i = 0; i < cor_pkg::COR_NUM_OUT; i++) begin
        divide_code_invalid_o[i] <= div_field[i] == 8'h00;
      end
    end
  end

endmodule
`default_nettype wire

// >>> tb/cor_regs_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module cor_regs_assertions (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ser_latch_i,
  input wire logic outputs_gate_pin_i,
  input wire logic [7:0][1:0] output_path_select_o,
  input wire logic [7:0][8:0] divide_ratio_o,
  input wire logic [7:0][3:0] output_delay_code_o,
  input wire logic [7:0][11:0] added_latency_ps_o,
  input wire logic [7:0] clock_output_en_o,
  input wire logic all_outputs_enable_o,
  input wire logic device_sleep_o,
  input wire logic pump_float_o,
  input wire logic [3:0] lock_indicator_sel_o,
  input wire logic [11:0] ref_divider_o,
  input wire logic ref_divider_invalid_o,
  input wire logic [17:0] feedback_divider_o,
  input wire logic feedback_divider_invalid_o,
  input wire logic pll_fixed_bits_bad_o
);
  // ------------------------------------------------------------
  // Per-output path consistency
  // ------------------------------------------------------------
  logic [7:0] lat_ok;
  logic [7:0] ratio_ok;
  logic [11:0] dly_ps;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      dly_ps = 12'h096 * output_delay_code_o[i];
      case (output_path_select_o[i])
        2'h0: lat_ok[i] = added_latency_ps_o[i] == 12'h000;
        2'h1: lat_ok[i] = added_latency_ps_o[i] == 12'h064;
        2'h2: lat_ok[i] = added_latency_ps_o[i] == 12'h190 + dly_ps;
        default: lat_ok[i] = added_latency_ps_o[i] == 12'h1f4 + dly_ps;
      endcase
      // Divided ratios are always even, bypassed divider is unity
      ratio_ok[i] = output_path_select_o[i][0] ? !divide_ratio_o[i][0] :
        divide_ratio_o[i] == 9'h001;
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  property p_latency; &lat_ok; endproperty
  property p_ratio; &ratio_ok; endproperty
  property p_enable;
    |clock_output_en_o |-> all_outputs_enable_o && !device_sleep_o;
  endproperty
  property p_gate;
    !outputs_gate_pin_i [*4] |-> clock_output_en_o == 8'h00;
  endproperty
  property p_sleep;
    device_sleep_o |-> pump_float_o && lock_indicator_sel_o == 4'h0;
  endproperty
  property p_rdiv_bad;
    ref_divider_invalid_o == (ref_divider_o == 12'h000);
  endproperty
  property p_fb_bad;
    feedback_divider_invalid_o == (feedback_divider_o == 18'h00000);
  endproperty
  property p_defaults;
    $past(rst_i) |-> ref_divider_o == 12'h00a && all_outputs_enable_o &&
      feedback_divider_o == 18'h002f8 && clock_output_en_o == 8'h00 &&
      !pll_fixed_bits_bad_o;
  endproperty
  // Registers only move on a commit, which needs the latch to rise
  property p_hold;
    ser_latch_i [*8] |-> $stable(ref_divider_o) &&
      $stable(output_path_select_o);
  endproperty
  a_latency: assert property (p_latency) else $error("latency wrong");
  a_ratio: assert property (p_ratio) else $error("ratio wrong");
  a_enable: assert property (p_enable) else $error("enable leak");
  a_gate: assert property (p_gate) else $error("gate ignored");
  a_sleep: assert property (p_sleep) else $error("sleep leak");
  a_rdiv_bad: assert property (p_rdiv_bad) else $error("rdiv flag");
  a_fb_bad: assert property (p_fb_bad) else $error("fb flag");
  a_defaults: assert property (p_defaults) else $error("defaults");
  a_hold: assert property (p_hold) else $error("moved idle");
  c_both: cover property (output_path_select_o[7] == 2'h3);
  c_sleep: cover property (device_sleep_o);
  c_gate: cover property ($fell(outputs_gate_pin_i));
endmodule
`default_nettype wire

// >>> tb/cor_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module cor_host_model (
  input wire logic clk_i,
  output var logic ser_clk_o,
  output var logic ser_data_o,
  output var logic ser_latch_o,
  output var logic sync_n_o
);
  // Serial clock rests low between words
  initial begin
    ser_clk_o = 1'b0;
    ser_data_o = 1'b0;
    ser_latch_o = 1'b1;
    sync_n_o = 1'b1;
  end
  // Pulsed low once the dividers are written, to align outputs
  task automatic sync_pulse();
    sync_n_o <= 1'b0;
    phase();
    sync_n_o <= 1'b1;
  endtask
  task automatic phase();
    repeat (4) @(posedge clk_i);
  endtask
  task automatic send(input logic [31:0] word);
    ser_latch_o <= 1'b0;
    for (int b = 31; b >= 0; b--) begin
      ser_data_o <= word[b];
      phase();
      ser_clk_o <= 1'b1;
      phase();
      ser_clk_o <= 1'b0;
    end
    phase();
    ser_latch_o <= 1'b1;
    // Released data must not look like the last bit
    ser_data_o <= ~word[0];
  endtask
endmodule
`default_nettype wire

// >>> tb/cor_regs_bench.sv
`timescale 1ns/1ns
`default_nettype none
module cor_regs_bench;
  typedef struct packed {
    logic [31:0] word;
    logic [8:0] ratio;
    logic [11:0] lat;
    logic en;
  } cor_row_t;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic outputs_gate_pin_i = 1'b1;
  logic ser_clk_i, ser_data_i, ser_latch_i;
  logic [7:0][1:0] output_path_select_o;
  logic [7:0][8:0] divide_ratio_o;
  logic [7:0][3:0] output_delay_code_o;
  logic [7:0][11:0] added_latency_ps_o;
  logic [7:0] clock_output_en_o, divide_code_invalid_o;
  logic lock_detect_prescale_o, all_outputs_enable_o, device_sleep_o;
  logic pump_float_o, pump_polarity_o, ref_divider_invalid_o;
  logic feedback_divider_invalid_o, pll_fixed_bits_bad_o;
  logic [1:0] pump_gain_o;
  logic [3:0] lock_indicator_sel_o;
  logic [11:0] ref_divider_o;
  logic [17:0] feedback_divider_o;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  cor_row_t rows [4] = '{
    '{32'h0003_0531, 9'h00a, 12'h064, 1'b1},
    '{32'h0004_fff2, 9'h001, 12'ha5a, 1'b0},
    '{32'h0007_fff7, 9'h1fe, 12'habe, 1'b1},
    '{32'h0001_0240, 9'h001, 12'h000, 1'b1}
  };
  cor_regs cor_regs_i (.*);
  cor_host_model cor_host_model_i (.clk_i(ref_clk_i), .ser_clk_o(ser_clk_i),
    .ser_data_o(ser_data_i), .ser_latch_o(ser_latch_i), .sync_n_o());
  initial begin
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic put(input logic [31:0] w);
    cor_host_model_i.send(w);
    repeat (6) @(posedge ref_clk_i);
  endtask
  task automatic finish_test();
    $display("Comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Hang guard, well above the ~3500 cycles the sequence needs
  // ------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 10000) begin
      failures++;
      finish_test();
    end
  end
  initial begin
    int n;
    repeat (12) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    chk(ref_divider_o, 12'h00a);
    chk(feedback_divider_o, 18'h002f8);
    chk({all_outputs_enable_o, clock_output_en_o}, 9'h100);
    // Leaving reset must not commit anything into register 0
    repeat (4) @(posedge ref_clk_i);
    chk(divide_code_invalid_o, 8'h00);
    chk(divide_ratio_o[0], 9'h001);
    foreach (rows[r]) begin
      put(rows[r].word);
      n = rows[r].word[2:0];
      chk(divide_ratio_o[n], rows[r].ratio);
      chk(added_latency_ps_o[n], rows[r].lat);
      chk(clock_output_en_o[n], rows[r].en);
      chk(output_delay_code_o[n], rows[r].word[7:4]);
      chk(output_path_select_o[n], rows[r].word[18:17]);
    end
    cor_host_model_i.sync_pulse();
    chk(clock_output_en_o, 8'h83);
    outputs_gate_pin_i <= 1'b0;
    repeat (5) @(posedge ref_clk_i);
    chk(clock_output_en_o, 8'h00);
    outputs_gate_pin_i <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    chk(clock_output_en_o, 8'h83);
    put(32'h235f_ff0e);
    chk({all_outputs_enable_o, pump_float_o, pump_polarity_o}, 3'h3);
    chk(lock_indicator_sel_o, 4'h5);
    chk(ref_divider_o, 12'hfff);
    chk(clock_output_en_o, 8'h00);
    put(32'h3c00_000e);
    chk({device_sleep_o, ref_divider_invalid_o, pll_fixed_bits_bad_o,
      pump_float_o}, 4'hf);
    chk(lock_indicator_sel_o, 4'h0);
    put(32'h83ff_ff0f);
    chk({pump_gain_o, feedback_divider_o}, 20'hbffff);
    put(32'h0000_000f);
    chk(feedback_divider_invalid_o, 1'b1);
    put(32'h0000_800b);
    put(32'hffff_fff9);
    chk({lock_detect_prescale_o, ref_divider_o}, 13'h1000);
    put(32'h8007_fff0);
    chk({lock_detect_prescale_o, ref_divider_o, clock_output_en_o},
      21'h00a00);
    chk(output_path_select_o[0], 2'h0);
    chk(divide_ratio_o[7], 9'h001);
    put(32'h0003_0210);
    chk(divide_ratio_o[0], 9'h004);
    chk(clock_output_en_o, 8'h01);
    put(32'h0000_0003);
    chk(divide_code_invalid_o, 8'h08);
    finish_test();
  end
endmodule
bind cor_regs cor_regs_assertions cor_regs_assertions_i (.*);
`default_nettype wire
